// ==== verification/clamp_timing_generator_bench.sv ====
// Self-checking bench for the restore window generator.
// Assumes the sync source model and the design files are compiled first.
`timescale 1ns/1ps
`include "clamp_regs.svh"
module clamp_timing_generator_bench;
   logic clock, rst, ce, hsync, restore_pin, reg_wr_en, reg_rd_en, restore_active;
   logic [7:0] adc_code, reg_addr, reg_wdata, reg_rdata, restore_offset, rd;
   int miscompares = 0;
   int num_checks = 0;

   // Pixel clock, 25 ns period
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   sync_source_model u_src (.clock(clock), .hsync(hsync), .restore_pin(restore_pin));

   clamp_timing_generator u_dut (.clock(clock), .rst(rst), .ce(ce), .hsync(hsync),
      .restore_pin(restore_pin), .adc_code(adc_code), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .restore_active(restore_active),
      .restore_offset(restore_offset));

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and stop
   task automatic end_sim;
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One-cycle write strobe, then an idle cycle
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr_en = 1'b1;
      @(negedge clock);
      reg_wr_en = 1'b0;
      @(negedge clock);
   endtask

   // One-cycle read strobe, data taken after the accepting edge
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      reg_addr = addr;
      reg_rd_en = 1'b1;
      @(negedge clock);
      reg_rd_en = 1'b0;
      data = reg_rdata;
      @(negedge clock);
   endtask

   task automatic t_regs;
      reg_read(`RESTORE_ADDR_START_DELAY, rd);
      check(rd, `RESTORE_START_DELAY_RESET);
      reg_read(`RESTORE_ADDR_LENGTH, rd);
      check(rd, `RESTORE_LENGTH_RESET);
      reg_read(8'h7f, rd);
      check(rd, 8'h00);
      ce = 1'b0;
      reg_write(`RESTORE_ADDR_LENGTH, 8'h55);
      ce = 1'b1;
      reg_write(`RESTORE_ADDR_START_DELAY, 8'hff);
      reg_read(`RESTORE_ADDR_START_DELAY, rd);
      check(rd, 8'hff);
      reg_read(`RESTORE_ADDR_LENGTH, rd);
      check(rd, `RESTORE_LENGTH_RESET);
      reg_write(`RESTORE_ADDR_STATUS, 8'hff);
      reg_read(`RESTORE_ADDR_STATUS, rd);
      check(rd, 8'h00);
   endtask

   task automatic t_internal(input logic [7:0] p, input logic [7:0] l);
      int d;
      int w;
      d = -1;
      w = 0;
      reg_write(`RESTORE_ADDR_START_DELAY, p);
      reg_write(`RESTORE_ADDR_LENGTH, l);
      u_src.set_pin(1'b1);
      u_src.send_line(4);
      for (int i = 1; i <= p + l + 12; i++) begin
         @(negedge clock);
         if (restore_active === 1'b1) begin
            w++;
            if (d < 0) d = i;
         end
      end
      check(8'(w), l);
      if (l != 8'h00) check({7'h00, d >= p + 3 && d <= p + 5}, 8'h01);
      u_src.set_pin(1'b0);
   endtask

   task automatic t_external(input logic pol);
      reg_write(`RESTORE_ADDR_CONTROL, {6'h00, pol, 1'b1});
      for (int v = 0; v < 2; v++) begin
         u_src.set_pin(v[0]);
         repeat (5) @(negedge clock);
         check({7'h00, restore_active}, {7'h00, v[0] ^ pol});
      end
      reg_read(`RESTORE_ADDR_CONTROL, rd);
      check(rd, {6'h00, pol, 1'b1});
      reg_read(`RESTORE_ADDR_STATUS, rd);
      check(rd, {7'h00, !pol});
   endtask

   // offset servo during and outside the window
   task automatic t_servo;
      logic [7:0] o;
      reg_write(`RESTORE_ADDR_CONTROL, 8'h01);
      adc_code = 8'h40;
      u_src.set_pin(1'b1);
      repeat (6) @(negedge clock);
      o = restore_offset;
      repeat (10) @(negedge clock);
      check(restore_offset, o + 8'h0a);
      adc_code = 8'h00;
      repeat (2) @(negedge clock);
      o = restore_offset;
      repeat (3) @(negedge clock);
      check(restore_offset, o - 8'h03);
      adc_code = 8'h40;
      u_src.set_pin(1'b0);
      repeat (6) @(negedge clock);
      o = restore_offset;
      repeat (10) @(negedge clock);
      check(restore_offset, o);
   endtask

   // Reset, then the scenarios
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      adc_code = 8'h00;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      t_regs;
      t_internal(8'h08, 8'h14);
      t_internal(8'h00, 8'h01);
      t_internal(8'h05, 8'h00);
      t_internal(8'hff, 8'h03);
      t_external(1'b0);
      t_external(1'b1);
      t_servo;
      end_sim;
   end
endmodule // clamp_timing_generator_bench

// ==== verification/sync_source_model.sv ====
// Graphics source model: drives horizontal sync and the external restore pin.
// Assumes the bench calls its tasks just after a falling edge of the pixel clock.
`timescale 1ns/1ps
module sync_source_model (
   // Pixel clock
   input wire logic clock,
   // Pins towards the block
   output logic hsync,
   output logic restore_pin
);
   // Idle pins: sync inactive, restore pin low
   initial begin
      hsync = 1'b0;
      restore_pin = 1'b0;
   end

   // One sync pulse, trailing edge lands on a falling clock edge
   task automatic send_line(input int width);
      hsync = 1'b1;
      repeat (width) @(negedge clock);
      hsync = 1'b0;
   endtask

   task automatic set_pin(input logic level);
      restore_pin = level;
   endtask
endmodule // sync_source_model

// ==== verilog/clamp_pkg.sv ====
// Types used by the restore timing generator.
// Assumes nothing beyond a SystemVerilog compiler.
package clamp_pkg;

   // Internal generator states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_place = 2'b01,
      st_hold = 2'b10
   } restore_state_e;

endpackage

// ==== verilog/clamp_regs.svh ====
// Register offsets, field positions and reset values of the restore timing block.
// Assumes inclusion by every file that decodes or checks these registers.
`ifndef CLAMP_REGS_SVH
`define CLAMP_REGS_SVH

// Register offsets on the register write/read port
`define RESTORE_ADDR_START_DELAY 8'h00
`define RESTORE_ADDR_LENGTH 8'h01
`define RESTORE_ADDR_CONTROL 8'h02
`define RESTORE_ADDR_STATUS 8'h03

// Reset values
`define RESTORE_START_DELAY_RESET 8'h08
`define RESTORE_LENGTH_RESET 8'h14
`define RESTORE_OFFSET_RESET 8'h00

// Control field positions
`define RESTORE_CTRL_EXT_BIT 0
`define RESTORE_CTRL_POL_BIT 1

// Offset trim limits
`define RESTORE_OFFSET_MAX 8'hff
`define RESTORE_OFFSET_MIN 8'h00
`define RESTORE_CODE_BLACK 8'h00

`endif

// ==== verilog/clamp_timing_generator.sv ====
// Black-level restore window generator with offset trim servo.
// Assumes clock is the PLL pixel clock; hsync and the restore pin are asynchronous
// pins; adc_code comes from logic on the same clock.
`timescale 1ns/1ps
`include "clamp_regs.svh"

// Functional notes
// - Restore starts after placement count from sync trailing edge
// - Internal restore lasts the programmed length
// - Placement and length are 8-bit unsigned
// - External select takes timing from restore pin
// - Pin active level follows polarity bit
// - Trim offset toward black during restore, hold after
// - Without hsync only external timing is usable
// - Counted clock is the sync-locked PLL clock
module clamp_timing_generator (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Pins from the graphics source
   input wire logic hsync,
   input wire logic restore_pin,
   // Converter code on the pixel clock
   input wire logic [7:0] adc_code,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Restore outputs
   output logic restore_active,
   output logic [7:0] restore_offset
);

   logic [7:0] restore_start_delay;
   logic [7:0] restore_length;
   logic external_restore_select;
   logic restore_input_polarity;
   logic hsync_s1, hsync_s2, hsync_d;
   logic restore_s1, restore_s2;
   logic trail_edge;
   logic next_restore_active;
   clamp_pkg::restore_state_e state, next_state;

   count_if place_c ();
   count_if hold_c ();

   // Placement counter
   restore_counter u_place (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .port_c(place_c.cnt)
   );

   // Length counter
   restore_counter u_hold (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .port_c(hold_c.cnt)
   );

   // Pin synchronisers and sync edge history
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hsync_s1 <= 1'b0;
         hsync_s2 <= 1'b0;
         hsync_d <= 1'b0;
         restore_s1 <= 1'b0;
         restore_s2 <= 1'b0;
      end else if (ce) begin
         hsync_s1 <= hsync;
         hsync_s2 <= hsync_s1;
         hsync_d <= hsync_s2;
         restore_s1 <= restore_pin;
         restore_s2 <= restore_s1;
      end
   end

   assign trail_edge = hsync_d && !hsync_s2; // Sync falling edge

   // Register writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         restore_start_delay <= `RESTORE_START_DELAY_RESET;
         restore_length <= `RESTORE_LENGTH_RESET;
         external_restore_select <= 1'b0;
         restore_input_polarity <= 1'b0;
      end else if (ce && reg_wr_en) begin
         if (reg_addr == `RESTORE_ADDR_START_DELAY) begin
            restore_start_delay <= reg_wdata;
         end
         if (reg_addr == `RESTORE_ADDR_LENGTH) begin
            restore_length <= reg_wdata;
         end
         if (reg_addr == `RESTORE_ADDR_CONTROL) begin
            external_restore_select <= reg_wdata[`RESTORE_CTRL_EXT_BIT];
            restore_input_polarity <= reg_wdata[`RESTORE_CTRL_POL_BIT];
         end
      end
   end

   // Registered read data, unmapped reads zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd_en) begin
         case (reg_addr)
            `RESTORE_ADDR_START_DELAY: reg_rdata <= restore_start_delay;
            `RESTORE_ADDR_LENGTH: reg_rdata <= restore_length;
            `RESTORE_ADDR_CONTROL: reg_rdata <= {6'h00, restore_input_polarity,
               external_restore_select};
            `RESTORE_ADDR_STATUS: reg_rdata <= {5'h00, state, restore_active};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Generator next state and counter loads
   always_comb begin
      next_state = state;
      place_c.load = 1'b0;
      place_c.load_value = restore_start_delay - 8'h01;
      hold_c.load = 1'b0;
      hold_c.load_value = restore_length - 8'h01;
      if (trail_edge) begin
         if (restore_start_delay != 8'h00) begin
            next_state = clamp_pkg::st_place;
            place_c.load = 1'b1;
         end else if (restore_length != 8'h00) begin
            next_state = clamp_pkg::st_hold;
            hold_c.load = 1'b1;
         end else begin
            next_state = clamp_pkg::st_idle;
         end
      end else begin
         unique case (state)
            clamp_pkg::st_idle: begin
               next_state = clamp_pkg::st_idle;
            end
            clamp_pkg::st_place: begin
               if (place_c.done) begin
                  if (restore_length != 8'h00) begin
                     next_state = clamp_pkg::st_hold;
                     hold_c.load = 1'b1;
                  end else begin
                     next_state = clamp_pkg::st_idle;
                  end
               end
            end
            clamp_pkg::st_hold: begin
               if (hold_c.done) begin
                  next_state = clamp_pkg::st_idle;
               end
            end
            default: begin
               next_state = clamp_pkg::st_idle;
            end
         endcase
      end
   end

   // Generator state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= clamp_pkg::st_idle;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Restore source select
   always_comb begin
      if (external_restore_select) begin
         next_restore_active = restore_s2 ^ restore_input_polarity;
      end else begin
         next_restore_active = (state == clamp_pkg::st_hold);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         restore_active <= 1'b0;
      end else if (ce) begin
         restore_active <= next_restore_active;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         restore_offset <= `RESTORE_OFFSET_RESET;
      end else if (ce && restore_active) begin
         if (adc_code != `RESTORE_CODE_BLACK) begin
            if (restore_offset != `RESTORE_OFFSET_MAX) begin
               restore_offset <= restore_offset + 8'h01;
            end
         end else if (restore_offset != `RESTORE_OFFSET_MIN) begin
            restore_offset <= restore_offset - 8'h01;
         end
      end
   end

   // Helper: enabled cycles spent holding since the length counter was last loaded
   logic [8:0] hold_cycles;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hold_cycles <= 9'h000;
      end else if (ce) begin
         if (next_state == clamp_pkg::st_hold
            && (state != clamp_pkg::st_hold || hold_c.load)) begin
            hold_cycles <= 9'h001;
         end else if (next_state == clamp_pkg::st_hold) begin
            hold_cycles <= hold_cycles + 9'h001;
         end else begin
            hold_cycles <= 9'h000;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_edge_arms_place: assert property (
      ce && trail_edge && restore_start_delay != 8'h00 |=> state == clamp_pkg::st_place)
      else $error("placement not armed on sync trailing edge");
   a_zero_delay_hold: assert property (
      ce && trail_edge && restore_start_delay == 8'h00 && restore_length != 8'h00
      |=> state == clamp_pkg::st_hold)
      else $error("zero placement did not start restore at once");
   a_place_to_hold: assert property (
      ce && !trail_edge && state == clamp_pkg::st_place && place_c.done
      && restore_length != 8'h00 |=> state == clamp_pkg::st_hold)
      else $error("placement expiry did not start restore");
   a_hold_length_bound: assert property (
      state == clamp_pkg::st_hold |-> hold_cycles <= {1'b0, restore_length})
      else $error("internal restore held past programmed length");
   a_hold_ends: assert property (
      ce && !trail_edge && state == clamp_pkg::st_hold && hold_c.done
      |=> state == clamp_pkg::st_idle)
      else $error("internal restore did not end on length expiry");
   a_delay_write: assert property (
      ce && reg_wr_en && reg_addr == `RESTORE_ADDR_START_DELAY
      |=> restore_start_delay == $past(reg_wdata))
      else $error("placement write not stored");
   a_ext_follows_pin: assert property (
      ce && external_restore_select
      |=> restore_active == ($past(restore_s2) ^ $past(restore_input_polarity)))
      else $error("restore output does not follow pin");
   a_pol_low_active: assert property (
      ce && external_restore_select && restore_input_polarity && !restore_s2
      |=> restore_active)
      else $error("low pin not active under inverted polarity");
   a_int_ignores_pin: assert property (
      ce && !external_restore_select |=> restore_active == $past(state == clamp_pkg::st_hold))
      else $error("internal restore disturbed by pin");
   a_offset_holds: assert property (
      ce && !restore_active |=> $stable(restore_offset))
      else $error("offset moved outside restore");
   a_offset_servo: assert property (
      ce && restore_active && adc_code != 8'h00 && restore_offset != 8'hff
      |=> restore_offset == $past(restore_offset) + 8'h01)
      else $error("offset not raised for non-black code");

   c_internal_hold: cover property (
      state == clamp_pkg::st_place ##[1:300] state == clamp_pkg::st_hold);
   c_external_restore: cover property (external_restore_select && restore_active);
   c_offset_settle: cover property (
      restore_active && adc_code == 8'h00 && restore_offset != 8'h00);

endmodule // clamp_timing_generator

// ==== verilog/count_if.sv ====
// Carrier between the generator control and one down counter.
// Assumes the counter and its controller share one clock.
`timescale 1ns/1ps
interface count_if;
   logic load;
   logic [7:0] load_value;
   logic done;

   modport ctrl (output load, output load_value, input done);
   modport cnt (input load, input load_value, output done);
endinterface

// ==== verilog/restore_counter.sv ====
// Loadable 8-bit down counter used for restore placement and length.
// Assumes load and load_value come from logic on the same clock.
`timescale 1ns/1ps
module restore_counter (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Count control
   count_if.cnt port_c
);

   logic [7:0] remaining;

   // Load or count down to zero, then rest
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         remaining <= 8'h00;
      end else if (ce) begin
         if (port_c.load) begin
            remaining <= port_c.load_value;
         end else if (remaining != 8'h00) begin
            remaining <= remaining - 8'h01;
         end
      end
   end

   // Expired once the count reaches zero
   assign port_c.done = (remaining == 8'h00);

endmodule // restore_counter
